/* verilog/rsw_pkg.sv */
// constants, register map and state codes of the reset/sleep/wake sequencer
// assumes a single 20 mhz clock domain shared by all users of the package
package rsw_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_NS     = 50;
	localparam int RC_TICK_NS = 1000;
	localparam int HOLD_MS    = 18;
	localparam int WDT_MS     = 18;
	localparam int RC_DIV     = (RC_TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_TICKS = (HOLD_MS * 1000000 + RC_TICK_NS - 1) / RC_TICK_NS;
	localparam int WDT_TICKS  = (WDT_MS * 1000000 + RC_TICK_NS - 1) / RC_TICK_NS;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_FUSE   = 8'h04;
	localparam logic [7:0] REG_IDENT  = 8'h08;
	localparam logic [7:0] REG_PADDR  = 8'h0c;
	localparam logic [7:0] REG_PDATA  = 8'h10;

	localparam int ST_PD_BIT    = 0;
	localparam int ST_TO_BIT    = 1;
	localparam int ST_RST_BIT   = 2;
	localparam int ST_SLEEP_BIT = 3;
	localparam int ST_CP_BIT    = 4;

	localparam int         FUSE_W       = 4;
	localparam int         FUSE_OSC_LSB = 0;
	localparam int         FUSE_WDT_BIT = 2;
	localparam int         FUSE_CP_BIT  = 3;
	localparam logic [3:0] FUSE_RESET   = 4'hf;

	localparam int          IDENT_W     = 16;
	localparam logic [15:0] IDENT_RESET = 16'hffff;
	localparam int          WORD_W      = 12;
	localparam logic [31:0] PROT_BASE   = 32'h0000_0040;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ---------------------------------------------------------------
	// sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		RSW_ST_RESET = 2'b00,
		RSW_ST_HOLD  = 2'b01,
		RSW_ST_RUN   = 2'b10,
		RSW_ST_SLEEP = 2'b11
	} rsw_state_t;

endpackage

/* verilog/rsw_tick_timer.sv */
// period timer advanced by a slow tick enable
// assumes tick is a one-cycle pulse on aclk; clr dominates run
module rsw_tick_timer #(
	parameter int CNT_W = 16
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             clr,
	input  wire logic             run,
	input  wire logic             tick,
	input  wire logic [CNT_W-1:0] period,
	output logic                  expired
);

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic             fired;
	} rsw_tmr_t;

	rsw_tmr_t s_q;
	rsw_tmr_t s_d;

	always_comb
	begin
		s_d       = s_q;
		s_d.fired = 1'b0;
		if (clr)
		begin
			s_d.count = '0;
		end
		else if (run && tick)
		begin
			if (s_q.count == period - CNT_W'(1))
			begin
				s_d.count = '0;
				s_d.fired = 1'b1;
			end
			else
			begin
				s_d.count = s_q.count + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign expired = s_q.fired;

endmodule

/* verilog/rsw_sequencer.sv */
// reset, sleep and wake sequencer with fuse and protection logic, axi4-lite slave
// assumes aresetn is the power-on reset; master_clear_n and prog_mode are async pins;
// sleep_exec and clrwdt_exec are one-cycle pulses from the core on aclk
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.

// Summary of operation
// R1 - hold reset one period after master-clear high
// R2 - watchdog time-out restarts the hold timer
// R3 - power-up sets reset latch, clears timer
// R4 - timer counts only with master-clear high
// R5 - sleep instruction enters power-down
// R6 - sleep clears watchdog and pd, sets to, stops oscillator
// R7 - pins keep their state during sleep
// R8 - wake on watchdog or master-clear pulse
// R9 - one hold period after any wake-up
// R10 - power-down flag set at power-on
// R11 - time-out flag tells wake source
// R12 - four fuses: oscillator, watchdog, protection
// R13 - 16 identifier bits, programmer only
// R14 - protection active when fuse is zero
// R15 - protected: refuse program words from 040h
// R16 - protected: fuses and identifier stay readable
// R17 - protected verify returns scrambled low nibble
// R18 - watchdog time-out clears time-out flag
// R19 - watchdog time-out resets the device
// R20 - watchdog fuse at zero disables permanently
// R21 - master-clear low holds reset
// R22 - hold timed from free-running rc tick
// R23 - sleep side effects in executing cycle
module rsw_sequencer #(
	parameter int ADDR_W     = 8,
	parameter int IO_W       = 20,
	parameter int PM_AW      = 11,
	parameter int HOLD_TICKS = rsw_pkg::HOLD_TICKS,
	parameter int WDT_TICKS  = rsw_pkg::WDT_TICKS
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	input  wire logic              master_clear_n,
	input  wire logic              prog_mode,
	input  wire logic              sleep_exec,
	input  wire logic              clrwdt_exec,
	input  wire logic [IO_W-1:0]   core_io_out,
	input  wire logic [IO_W-1:0]   core_io_oe,
	output logic [IO_W-1:0]        pin_io_out,
	output logic [IO_W-1:0]        pin_io_oe,
	output logic                   core_reset,
	output logic                   osc_drive_en,
	output logic [1:0]             osc_type,
	output logic                   wdt_enabled,
	output logic                   powerdown_flag,
	output logic                   timeout_flag
);

	localparam int DIV_W  = $clog2(rsw_pkg::RC_DIV) + 1;
	localparam int HOLD_W = $clog2(HOLD_TICKS) + 1;
	localparam int WDT_W  = $clog2(WDT_TICKS) + 1;
	localparam int FUSE_W  = rsw_pkg::FUSE_W;
	localparam int IDENT_W = rsw_pkg::IDENT_W;

	typedef struct packed {
		logic                        master_clear_n_m;
		logic                        master_clear_n_s;
		logic                        prog_m;
		logic                        prog_s;
		logic [DIV_W-1:0]            div;
		logic                        rc_tick;
		rsw_pkg::rsw_state_t         state;
		logic                        pd;
		logic                        to;
		logic [rsw_pkg::FUSE_W-1:0]  fuse;
		logic [rsw_pkg::IDENT_W-1:0] ident;
		logic [PM_AW-1:0]            paddr;
		logic [IO_W-1:0]             pin_out;
		logic [IO_W-1:0]             pin_oe;
		logic                        aw_got;
		logic [ADDR_W-1:0]           aw_addr;
		logic                        w_got;
		logic [31:0]                 w_data;
		logic [3:0]                  w_strb;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        rvalid;
		logic [31:0]                 rdata;
		logic [1:0]                  rresp;
	} rsw_seq_t;

	rsw_seq_t s_q;
	rsw_seq_t s_d;

	logic [rsw_pkg::WORD_W-1:0] pmem [0:(1 << PM_AW) - 1];
	logic                       mem_we;
	logic                       hold_exp;
	logic                       wdt_exp;
	logic                       wdt_clr;
	logic                       prot;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// a protected verify must not let the word be rebuilt: nibbles folded together
	function automatic logic [rsw_pkg::WORD_W-1:0] scramble(input logic [rsw_pkg::WORD_W-1:0] w);
		return {8'h00, w[11:8] ^ w[7:4] ^ w[3:0]};
	endfunction

	assign prot = !s_q.fuse[rsw_pkg::FUSE_CP_BIT];  // see R14

	// ---------------------------------------------------------------
	// timers
	// ---------------------------------------------------------------
	// hold timer restarts whenever the sequencer is outside the hold state
	rsw_tick_timer #(
		.CNT_W (HOLD_W)
	) u_hold (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (s_q.state != rsw_pkg::RSW_ST_HOLD),  // see R3
		.run     (s_q.state == rsw_pkg::RSW_ST_HOLD),  // see R4
		.tick    (s_q.rc_tick),                        // see R22
		.period  (HOLD_W'(HOLD_TICKS)),
		.expired (hold_exp)
	);

	assign wdt_clr = !s_q.fuse[rsw_pkg::FUSE_WDT_BIT]
		|| (s_q.state == rsw_pkg::RSW_ST_RESET) || (s_q.state == rsw_pkg::RSW_ST_HOLD)
		|| ((s_q.state == rsw_pkg::RSW_ST_RUN) && (sleep_exec || clrwdt_exec));  // see R6, R20, R23

	rsw_tick_timer #(
		.CNT_W (WDT_W)
	) u_wdt (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (wdt_clr),
		.run     (s_q.fuse[rsw_pkg::FUSE_WDT_BIT]),
		.tick    (s_q.rc_tick),
		.period  (WDT_W'(WDT_TICKS)),
		.expired (wdt_exp)
	);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		s_d    = s_q;
		mem_we = 1'b0;

		s_d.master_clear_n_m = master_clear_n;
		s_d.master_clear_n_s = s_q.master_clear_n_m;
		s_d.prog_m = prog_mode;
		s_d.prog_s = s_q.prog_m;

		// rc tick keeps running through sleep, unlike the main oscillator
		s_d.rc_tick = 1'b0;
		if (s_q.div == DIV_W'(rsw_pkg::RC_DIV - 1))
		begin
			s_d.div     = '0;
			s_d.rc_tick = 1'b1;  // see R22
		end
		else
		begin
			s_d.div = s_q.div + DIV_W'(1);
		end

		if (!s_q.master_clear_n_s)
		begin
			s_d.state = rsw_pkg::RSW_ST_RESET;  // see R21, R8
		end
		else
		begin
			unique case (s_q.state)
				rsw_pkg::RSW_ST_RESET:
					s_d.state = rsw_pkg::RSW_ST_HOLD;  // see R1, R9
				rsw_pkg::RSW_ST_HOLD:
				begin
					if (hold_exp)
						s_d.state = rsw_pkg::RSW_ST_RUN;  // see R4
				end
				rsw_pkg::RSW_ST_RUN:
				begin
					// a time-out is a reset and outranks a sleep in the same cycle
					if (wdt_exp)
					begin
						s_d.to    = 1'b0;                  // see R18
						s_d.state = rsw_pkg::RSW_ST_HOLD;  // see R2, R19
					end
					else if (sleep_exec)
					begin
						s_d.pd    = 1'b0;                   // see R6, R10, R23
						s_d.to    = 1'b1;                   // see R6, R11
						s_d.state = rsw_pkg::RSW_ST_SLEEP;  // see R5
					end
				end
				rsw_pkg::RSW_ST_SLEEP:
				begin
					if (wdt_exp)
					begin
						s_d.to    = 1'b0;                  // see R11, R18
						s_d.state = rsw_pkg::RSW_ST_HOLD;  // see R8, R9
					end
				end
			endcase
		end

		if (s_q.state != rsw_pkg::RSW_ST_SLEEP)
		begin
			s_d.pin_out = core_io_out;
			s_d.pin_oe  = core_io_oe;
		end

		// axi4-lite write channel: address and data taken in either order
		if (awvalid && awready)
		begin
			s_d.aw_got  = 1'b1;
			s_d.aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			s_d.w_got  = 1'b1;
			s_d.w_data = wdata;
			s_d.w_strb = wstrb;
		end
		if (s_q.bvalid && bready)
			s_d.bvalid = 1'b0;

		if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
		begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = rsw_pkg::RESP_SLVERR;
			if (s_q.prog_s)
			begin
				unique case (s_q.aw_addr[7:0])
					rsw_pkg::REG_FUSE:
					begin
						// eprom cells only go to zero, so a cleared fuse stays cleared
						s_d.fuse  = s_q.fuse & FUSE_W'(merge_strb(32'(s_q.fuse), s_q.w_data,
							s_q.w_strb));  // see R12, R15, R20
						s_d.bresp = rsw_pkg::RESP_OKAY;
					end
					rsw_pkg::REG_IDENT:
					begin
						s_d.ident = IDENT_W'(merge_strb(32'(s_q.ident), s_q.w_data,
							s_q.w_strb));  // see R13, R15
						s_d.bresp = rsw_pkg::RESP_OKAY;
					end
					rsw_pkg::REG_PADDR:
					begin
						s_d.paddr = PM_AW'(merge_strb(32'(s_q.paddr), s_q.w_data, s_q.w_strb));
						s_d.bresp = rsw_pkg::RESP_OKAY;
					end
					rsw_pkg::REG_PDATA:
					begin
						if (!prot || (32'(s_q.paddr) < rsw_pkg::PROT_BASE))
						begin
							mem_we    = 1'b1;  // see R15
							s_d.bresp = rsw_pkg::RESP_OKAY;
						end
					end
					default:
						s_d.bresp = rsw_pkg::RESP_SLVERR;
				endcase
			end
		end

		// axi4-lite read channel
		if (s_q.rvalid && rready)
			s_d.rvalid = 1'b0;
		if (arvalid && arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = '0;
			s_d.rresp  = rsw_pkg::RESP_OKAY;
			unique case (araddr[7:0])
				rsw_pkg::REG_STATUS:
				begin
					s_d.rdata[rsw_pkg::ST_PD_BIT]    = s_q.pd;
					s_d.rdata[rsw_pkg::ST_TO_BIT]    = s_q.to;
					s_d.rdata[rsw_pkg::ST_RST_BIT]   = s_q.state != rsw_pkg::RSW_ST_RUN;
					s_d.rdata[rsw_pkg::ST_SLEEP_BIT] = s_q.state == rsw_pkg::RSW_ST_SLEEP;
					s_d.rdata[rsw_pkg::ST_CP_BIT]    = prot;
				end
				rsw_pkg::REG_FUSE:
					s_d.rdata = 32'(s_q.fuse);  // see R16
				rsw_pkg::REG_IDENT:
				begin
					if (s_q.prog_s)
						s_d.rdata = 32'(s_q.ident);  // see R13, R16
					else
						s_d.rresp = rsw_pkg::RESP_SLVERR;
				end
				rsw_pkg::REG_PADDR:
					s_d.rdata = 32'(s_q.paddr);
				rsw_pkg::REG_PDATA:
				begin
					if (!s_q.prog_s)
						s_d.rresp = rsw_pkg::RESP_SLVERR;
					else if (prot)
						s_d.rdata = 32'(scramble(pmem[s_q.paddr]));  // see R17
					else
						s_d.rdata = 32'(pmem[s_q.paddr]);
				end
				default:
					s_d.rresp = rsw_pkg::RESP_SLVERR;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q       <= '0;
			s_q.state <= rsw_pkg::RSW_ST_RESET;  // see R3
			s_q.pd    <= 1'b1;                   // see R10
			s_q.to    <= 1'b1;
			s_q.fuse  <= rsw_pkg::FUSE_RESET;
			s_q.ident <= rsw_pkg::IDENT_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// program memory is not reset: its content is the stored code
	always_ff @(posedge aclk)
	begin
		if (mem_we)
			pmem[s_q.paddr] <= s_q.w_data[rsw_pkg::WORD_W-1:0];
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign awready        = !s_q.aw_got && !s_q.bvalid;
	assign wready         = !s_q.w_got && !s_q.bvalid;
	assign bvalid         = s_q.bvalid;
	assign bresp          = s_q.bresp;
	assign arready        = !s_q.rvalid;
	assign rvalid         = s_q.rvalid;
	assign rdata          = s_q.rdata;
	assign rresp          = s_q.rresp;
	assign pin_io_out     = s_q.pin_out;  // see R7
	assign pin_io_oe      = s_q.pin_oe;   // see R7
	assign core_reset     = s_q.state != rsw_pkg::RSW_ST_RUN;    // see R1, R9, R21
	assign osc_drive_en   = s_q.state != rsw_pkg::RSW_ST_SLEEP;  // see R6
	assign osc_type       = s_q.fuse[rsw_pkg::FUSE_OSC_LSB +: 2];
	assign wdt_enabled    = s_q.fuse[rsw_pkg::FUSE_WDT_BIT];
	assign powerdown_flag = s_q.pd;
	assign timeout_flag   = s_q.to;

endmodule

/* verif/rsw_seq_properties.sv */
// checker for the reset/sleep/wake sequencer ports
// assumes a bind to rsw_sequencer on its single aclk domain
module rsw_seq_properties #(
	parameter int IO_W       = 20,
	parameter int HOLD_TICKS = 8
) (
	input wire logic            aclk,
	input wire logic            aresetn,
	input wire logic            master_clear_n,
	input wire logic            sleep_exec,
	input wire logic            core_reset,
	input wire logic            osc_drive_en,
	input wire logic            powerdown_flag,
	input wire logic            timeout_flag,
	input wire logic            wdt_enabled,
	input wire logic [IO_W-1:0] pin_io_out,
	input wire logic            bvalid,
	input wire logic            bready,
	input wire logic [1:0]      bresp,
	input wire logic            rvalid,
	input wire logic            rready,
	input wire logic [31:0]     rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// slack covers pin sync and rc tick phase
	localparam int HOLD_LO = (HOLD_TICKS - 1) * rsw_pkg::RC_DIV;
	localparam int HOLD_HI = (HOLD_TICKS + 1) * rsw_pkg::RC_DIV + 8;
	int hold_cnt_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	always_ff @(posedge aclk)
	begin
		// time spent asleep is not part of the hold
		if (!aresetn || !core_reset || !master_clear_n || !osc_drive_en)
			hold_cnt_q <= 0;
		else
			hold_cnt_q <= hold_cnt_q + 1;
	end

	sequence s_sleep_taken;
		sleep_exec && !core_reset;
	endsequence
	sequence s_asleep;
		!powerdown_flag && timeout_flag && !osc_drive_en;
	endsequence

	property p_sleep_entry;
		s_sleep_taken |=> s_asleep;
	endproperty
	property p_master_clear_n_hold;
		!master_clear_n [*4] |-> core_reset;
	endproperty
	property p_pins_frozen;
		!osc_drive_en && !$past(osc_drive_en) |-> $stable(pin_io_out);
	endproperty
	property p_pd_clear;
		$fell(powerdown_flag) |-> $past(sleep_exec) && !$past(core_reset);
	endproperty
	property p_to_clear;
		$fell(timeout_flag) |-> core_reset && wdt_enabled;
	endproperty
	property p_hold_len;
		$fell(core_reset) |-> hold_cnt_q >= HOLD_LO && hold_cnt_q <= HOLD_HI;
	endproperty
	property p_b_stand;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	property p_r_stand;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty

	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");
	a_master_clear_n_hold: assert property (p_master_clear_n_hold) else $error("no reset on low clear");
	a_pins_frozen: assert property (p_pins_frozen) else $error("pins moved asleep");
	a_pd_clear: assert property (p_pd_clear) else $error("pd fell without sleep");
	a_to_clear: assert property (p_to_clear) else $error("to fell without reset");
	a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
	a_b_stand: assert property (p_b_stand) else $error("write response dropped");
	a_r_stand: assert property (p_r_stand) else $error("read data dropped");
endmodule

bind rsw_sequencer rsw_seq_properties #(
	.IO_W      (IO_W),
	.HOLD_TICKS(HOLD_TICKS)
) u_props (
	.aclk, .aresetn, .master_clear_n, .sleep_exec, .core_reset, .osc_drive_en,
	.powerdown_flag, .timeout_flag, .wdt_enabled, .pin_io_out,
	.bvalid, .bready, .bresp, .rvalid, .rready, .rdata
);

/* verif/rsw_ext_model.sv */
// model of the external reset circuit and the programmer mode pin
// assumes its tasks are called right after a rising aclk edge
module rsw_ext_model (
	input  wire logic aclk,
	output logic      master_clear_n,
	output logic      prog_mode
);
	timeunit 1ns;
	timeprecision 1ns;

	// clear pin has a pull-up, so it idles high
	initial
	begin
		master_clear_n = 1'b1;
		prog_mode = 1'b0;
	end

	task automatic master_clear_n_pulse(input int n);
		master_clear_n <= 1'b0;
		repeat (n) @(posedge aclk);
		master_clear_n <= 1'b1;
	endtask

	// extra edges let the pin synchroniser fill
	task automatic set_prog(input logic v);
		prog_mode <= v;
		repeat (4) @(posedge aclk);
	endtask
endmodule

/* verif/rsw_sequencer_tb.sv */
// self-checking bench: bus, sleep, wake, fuses and protection
// assumes shortened hold and watchdog counts via design parameters
module rsw_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int H = 8;
	localparam int W = 16;
	localparam int D = rsw_pkg::RC_DIV;
	localparam logic [1:0] OK = rsw_pkg::RESP_OKAY;
	localparam logic [1:0] ER = rsw_pkg::RESP_SLVERR;
	localparam logic [7:0] ST = rsw_pkg::REG_STATUS;
	localparam logic [7:0] FU = rsw_pkg::REG_FUSE;
	localparam logic [7:0] ID = rsw_pkg::REG_IDENT;
	localparam logic [7:0] PA = rsw_pkg::REG_PADDR;
	localparam logic [7:0] PM = rsw_pkg::REG_PDATA;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, master_clear_n, prog_mode;
	logic        sleep_exec, clrwdt_exec, core_reset, osc_drive_en, wdt_enabled;
	logic        powerdown_flag, timeout_flag, kick;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, osc_type;
	logic [19:0] core_io_out, core_io_oe, pin_io_out, pin_io_oe, p, q;
	logic [11:0] w;
	logic [15:0] idv;
	logic [1:0]  exp_b[$];
	logic [33:0] exp_r[$];
	int          err_count, n_tests, cyc;
	int          seed = 32'h2cb1ae09;

	rsw_sequencer #(.HOLD_TICKS(H), .WDT_TICKS(W)) DUT (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
		.rresp, .master_clear_n, .prog_mode, .sleep_exec, .clrwdt_exec, .core_io_out,
		.core_io_oe, .pin_io_out, .pin_io_oe, .core_reset, .osc_drive_en, .osc_type,
		.wdt_enabled, .powerdown_flag, .timeout_flag
	);
	rsw_ext_model PRT (.aclk, .master_clear_n, .prog_mode);

	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// ------------------------------------------------------------
	// checking and closing
	// ------------------------------------------------------------
	task automatic check(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// random pin traffic, periodic watchdog clears and the hang limit
	always @(posedge aclk)
	begin
		core_io_out <= 20'($random(seed));
		core_io_oe <= 20'($random(seed));
		clrwdt_exec <= kick && (cyc % 64) == 0;
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			check(1'b0, "timeout");
			summarize();
		end
	end

	always @(posedge aclk)
	begin
		if (bvalid === 1'b1 && bready)
			check(bresp === exp_b.pop_front(), "write response");
		if (rvalid === 1'b1 && rready)
			check({rresp, rdata} === exp_r.pop_front(), "read data");
	end

	// ------------------------------------------------------------
	// bus master and sequencing tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ah, wh, done;
		exp_b.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(negedge aclk);
			done = bvalid;
			ah = awvalid && awready;
			wh = wvalid && wready;
			@(posedge aclk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (done) break;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ah, done;
		exp_r.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(negedge aclk);
			done = rvalid;
			ah = arready;
			@(posedge aclk);
			if (ah) arvalid <= 1'b0;
			if (done) break;
		end
	endtask

	// osc selects the oscillator enable instead of core reset, for wake from sleep
	task automatic wait_lvl(input logic v, input int lo, input int hi, input bit osc = 1'b0);
		int n;
		n = 0;
		do
		begin
			@(negedge aclk);
			n++;
		end
		while ((osc ? osc_drive_en : core_reset) !== v && n <= hi);
		@(posedge aclk);
		check(n >= lo && n <= hi, "reset timing");
	endtask

	task automatic slp();
		sleep_exec <= 1'b1;
		@(posedge aclk);
		sleep_exec <= 1'b0;
		@(negedge aclk);
		check(!powerdown_flag && timeout_flag && !osc_drive_en, "sleep entry");
		p = pin_io_out;
		q = pin_io_oe;
		repeat (40) @(posedge aclk);
		check(pin_io_out === p && pin_io_oe === q && osc_drive_en === 1'b0, "pins frozen");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_exec} = 7'h00;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		kick = 1'b1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check(core_reset && powerdown_flag && timeout_flag, "power-on");
		wait_lvl(1'b0, (H - 1) * D, (H + 1) * D + 8);
		rd(FU, 32'hf, OK);
		rd(ID, 32'h0, ER);
		wr(FU, 32'h0, ER);
		PRT.set_prog(1'b1);
		rd(ID, 32'hffff, OK);
		rd(ST, 32'h3, OK);
		wr(ST, 32'h0, ER);
		rd(8'h14, 32'h0, ER);
		wr(8'h14, 32'h0, ER);
		w = 12'($random(seed));
		wr(PA, 32'h40, OK);
		wr(PM, {20'h0, w}, OK);
		rd(PM, {20'h0, w}, OK);
		wr(FU, 32'h7, OK);
		rd(ST, 32'h13, OK);
		wr(PM, 32'h0, ER);
		wr(PA, 32'h3f, OK);
		w = 12'($random(seed));
		wr(PM, {20'h0, w}, OK);
		rd(PM, {28'h0, w[11:8] ^ w[7:4] ^ w[3:0]}, OK);
		idv = 16'($random(seed));
		wr(ID, {16'h0, idv}, OK);
		rd(ID, {16'h0, idv}, OK);
		rd(FU, 32'h7, OK);
		PRT.set_prog(1'b0);
		slp();
		wait_lvl(1'b1, (W - 3) * D, (W + 1) * D, 1'b1);
		check(!timeout_flag && !powerdown_flag, "watchdog wake flags");
		wait_lvl(1'b0, (H - 1) * D, (H + 1) * D + 8);
		rd(ST, 32'h10, OK);
		slp();
		PRT.master_clear_n_pulse(8);
		@(negedge aclk);
		check(core_reset && timeout_flag && !powerdown_flag, "clear wake");
		wait_lvl(1'b0, (H - 1) * D, (H + 1) * D + 8);
		rd(ST, 32'h12, OK);
		PRT.set_prog(1'b1);
		wr(FU, 32'h3, OK);
		wr(FU, 32'hf, OK);
		rd(FU, 32'h3, OK);
		check(wdt_enabled === 1'b0 && osc_type === 2'h3, "fuse outputs");
		PRT.set_prog(1'b0);
		kick <= 1'b0;
		repeat (3 * W * D) @(posedge aclk);
		check(core_reset === 1'b0 && timeout_flag === 1'b1, "watchdog off");
		summarize();
	end
endmodule
